// ==== hdl/fps_consts.svh ====
// constants of the fault protection supervisor
// Behaviour
// - output below -300 mV latches phases high-z
// - reverse monitor stays active after over-voltage latch
// - reverse latch cleared by enable, supply, over-voltage
// - summed current above threshold flags over-current
// - reduced power states divide threshold by N
// - over-current truncates each phase on-time
// - over-current lasting 1ms latches phases high-z
// - over-current latch cleared by supply or enable
// - per-phase limit truncates that phase's duty
// - output above 3.4V latches low, conduction flag
// - target+400mV latches low, blanked in transitions
// - under-voltage lasting 1ms latches phases high-z
// - under-voltage is 300mV below target
// - over-voltage latch cleared by enable, supply, reverse
// - target check blanked until first final-target fall
// - disabled or supply lockout forces high-z
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH
`define FPS_CLK_HZ          10000000
`define FPS_PERSIST_US      1000
`define FPS_PERSIST_CYC     ((`FPS_CLK_HZ / 1000000) * `FPS_PERSIST_US)
`define FPS_NPH             4
`define FPS_CUR_W           12
// register byte offsets
`define FPS_REG_CTRL        5'h00
`define FPS_REG_THRESH      5'h04
`define FPS_REG_STATUS      5'h08
`define FPS_REG_IRQ_STAT    5'h0c
`define FPS_REG_IRQ_MASK    5'h10
// ctrl fields
`define FPS_CTRL_PS_BIT     0
`define FPS_CTRL_NPH_LSB    1
`define FPS_THRESH_RST      12'hfff
`define FPS_NPH_RST         2'h0
// event / interrupt status bit positions
`define FPS_EV_RV           0
`define FPS_EV_OV           1
`define FPS_EV_OC           2
`define FPS_EV_UV           3
`define FPS_EV_HOT          4
`define FPS_EV_W            5
`endif

// ==== hdl/fps_pkg.sv ====
// types of the fault protection supervisor
`default_nettype none
`include "fps_consts.svh"
package fps_pkg;
    typedef enum logic [1:0] {
        FPS_PWM_LOW  = 2'h0,
        FPS_PWM_HIGH = 2'h1,
        FPS_PWM_HIZ  = 2'h2
    } fps_pwm_t;
    typedef struct packed {
        logic rev_volt;     // output sense below -300 mV
        logic ov_fixed;     // above 3.4 V
        logic ov_target;    // above target + 400 mV
        logic under_volt;   // 300 mV or more below target
        logic over_temp;
    } fps_cmp_t;
    typedef enum logic [2:0] {
        FPS_ST_OFF   = 3'h1,
        FPS_ST_RUN   = 3'h2,
        FPS_ST_FAULT = 3'h4
    } fps_state_t;
endpackage
`default_nettype wire

// ==== hdl/fps_persist_timer.sv ====
// persistence timer: flag raised after a condition holds for a fixed count, held until the condition breaks
`timescale 1ns/10ps
`default_nettype none
`include "fps_consts.svh"
module fps_persist_timer #(
    parameter int unsigned CYCLES = `FPS_PERSIST_CYC
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    // condition and expiry
    input  wire logic cond_i,
    output logic      expired_o
);
    logic [31:0] cnt_q;

    // any break in the condition restarts the count, so only continuous hold expires
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || !cond_i)
        begin
            cnt_q     <= 32'h0;
            expired_o <= 1'b0;
        end
        else if (cnt_q < CYCLES - 1)
        begin
            cnt_q     <= cnt_q + 32'h1;
            expired_o <= 1'b0;
        end
        else
        begin
            expired_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/fps_oc_threshold.sv ====
// over-current threshold scaling and comparison
`timescale 1ns/10ps
`default_nettype none
`include "fps_consts.svh"
module fps_oc_threshold (
    // clock and reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   srst_i,
    // settings
    input  wire logic [`FPS_CUR_W-1:0]  thresh_i,
    input  wire logic                   reduced_i,
    input  wire logic [1:0]             nph_sel_i,
    // current
    input  wire logic [`FPS_CUR_W-1:0]  sum_i,
    output logic                        over_o
);
    logic [`FPS_CUR_W-1:0] eff_q;

    // divider registered: threshold changes are slow, avoids a long compare path
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            eff_q <= `FPS_THRESH_RST;
        else if (!reduced_i)
            eff_q <= thresh_i;
        else if (nph_sel_i == 2'h1)
            eff_q <= thresh_i / `FPS_CUR_W'(3);
        else if (nph_sel_i == 2'h2)
            eff_q <= thresh_i >> 1;
        else
            eff_q <= thresh_i >> 2;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            over_o <= 1'b0;
        else
            over_o <= sum_i > eff_q;
    end
endmodule
`default_nettype wire

// ==== hdl/fps_supervisor.sv ====
// fault protection supervisor top
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "fps_consts.svh"
module fps_supervisor (
    // clock and reset
    input  wire logic                       ref_clk_i,
    input  wire logic                       srst_i,
    // supply and enable
    input  wire logic                       enable_i,
    input  wire logic                       supply_ok_i,
    // comparators
    input  wire fps_pkg::fps_cmp_t          cmp_i,
    input  wire logic                       final_target_flag_i,
    input  wire logic                       vid_transition_i,
    input  wire logic [`FPS_CUR_W-1:0]      summed_current_sense_i,
    input  wire logic [`FPS_NPH-1:0]        phase_limit_i,
    // modulator
    input  wire logic [`FPS_NPH-1:0]        pwm_mod_i,
    // phase outputs
    output fps_pkg::fps_pwm_t [`FPS_NPH-1:0] pwm_o,
    output logic                            forced_conduction_flag_o,
    output logic                            thermal_alarm_n_o,
    output logic                            irq_o,
    // avalon-mm slave
    input  wire logic [4:0]                 avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [31:0]                avs_writedata_i,
    input  wire logic [3:0]                 avs_byteenable_i,
    output logic [31:0]                     avs_readdata_o,
    output logic                            avs_waitrequest_o
);
    import fps_pkg::*;

    // ==========================================================
    // registers
    logic [`FPS_CUR_W-1:0] thresh_q;
    logic                  reduced_q;
    logic [1:0]            nph_q;
    logic [`FPS_EV_W-1:0]  irq_stat_q;
    logic [`FPS_EV_W-1:0]  irq_mask_q;
    logic                  rv_latch_q;
    logic                  ov_latch_q;
    logic                  oc_latch_q;
    logic                  uv_latch_q;
    logic                  en_prev_q;
    logic                  blank_q;
    logic                  ftf_prev_q;
    logic                  done_q;
    fps_state_t            state_q;

    logic active;
    logic en_rise;
    logic over_cur;
    logic oc_exp;
    logic uv_exp;
    logic ov_now;
    logic wr_hit;
    logic [`FPS_EV_W-1:0] ev;

    // ==========================================================
    // enable and supply
    assign active  = enable_i && supply_ok_i;
    // a fresh enable or supply return clears all latches
    assign en_rise = active && !en_prev_q;

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            en_prev_q <= 1'b0;
        else
            en_prev_q <= active;
    end

    // ==========================================================
    // over-voltage blanking until first final-target fall
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            ftf_prev_q <= 1'b0;
        else
            ftf_prev_q <= final_target_flag_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || !active)
            blank_q <= 1'b1;
        else if (ftf_prev_q && !final_target_flag_i)
            blank_q <= 1'b0;
    end

    // fixed level is never blanked; target level blanked in transitions
    assign ov_now = active && (cmp_i.ov_fixed
                    || (cmp_i.ov_target && !blank_q && !vid_transition_i));

    // ==========================================================
    // current and persistence
    fps_oc_threshold u_oc (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .thresh_i  (thresh_q),
        .reduced_i (reduced_q),
        .nph_sel_i (nph_q),
        .sum_i     (summed_current_sense_i),
        .over_o    (over_cur)
    );

    fps_persist_timer #(.CYCLES(`FPS_PERSIST_CYC)) u_oc_tmr (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .cond_i    (over_cur && active),
        .expired_o (oc_exp)
    );

    fps_persist_timer #(.CYCLES(`FPS_PERSIST_CYC)) u_uv_tmr (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .cond_i    (cmp_i.under_volt && active),
        .expired_o (uv_exp)
    );

    // ==========================================================
    // fault latches
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            rv_latch_q <= 1'b0;
        else if (active && cmp_i.rev_volt)
            rv_latch_q <= 1'b1;
        else if (en_rise || ov_now)
            rv_latch_q <= 1'b0;
    end

    // reverse wins over over-voltage: crowbar can drive output negative
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            ov_latch_q <= 1'b0;
        else if (active && cmp_i.rev_volt)
            ov_latch_q <= 1'b0;
        else if (ov_now)
            ov_latch_q <= 1'b1;
        else if (en_rise)
            ov_latch_q <= 1'b0;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            oc_latch_q <= 1'b0;
        else if (oc_exp)
            oc_latch_q <= 1'b1;
        else if (en_rise)
            oc_latch_q <= 1'b0;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            uv_latch_q <= 1'b0;
        else if (uv_exp)
            uv_latch_q <= 1'b1;
        else if (en_rise)
            uv_latch_q <= 1'b0;
    end

    // ==========================================================
    // state
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            state_q <= FPS_ST_OFF;
        else
        begin
            case (state_q)
                FPS_ST_OFF:   if (active) state_q <= FPS_ST_RUN;
                FPS_ST_RUN:
                    if (!active)
                        state_q <= FPS_ST_OFF;
                    else if (rv_latch_q || ov_latch_q || oc_latch_q || uv_latch_q)
                        state_q <= FPS_ST_FAULT;
                FPS_ST_FAULT: if (!active) state_q <= FPS_ST_OFF;
                default:      state_q <= FPS_ST_OFF;
            endcase
        end
    end

    // ==========================================================
    // phase outputs, latches first
    genvar g;
    generate
        for (g = 0; g < `FPS_NPH; g++)
        begin : g_ph
            always_ff @(posedge ref_clk_i)
            begin
                if (srst_i || !active)
                    pwm_o[g] <= FPS_PWM_HIZ;
                else if (rv_latch_q || oc_latch_q || uv_latch_q)
                    pwm_o[g] <= FPS_PWM_HIZ;
                else if (ov_latch_q)
                    pwm_o[g] <= FPS_PWM_LOW;
                else if (over_cur || phase_limit_i[g])
                    pwm_o[g] <= FPS_PWM_LOW;
                else
                    pwm_o[g] <= pwm_mod_i[g] ? FPS_PWM_HIGH : FPS_PWM_LOW;
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            forced_conduction_flag_o <= 1'b0;
        else
            forced_conduction_flag_o <= active && ov_latch_q && !rv_latch_q;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            thermal_alarm_n_o <= 1'b1;
        else
            thermal_alarm_n_o <= !cmp_i.over_temp;
    end

    // ==========================================================
    // interrupts: set wins over write-one-to-clear
    assign ev[`FPS_EV_RV]  = rv_latch_q;
    assign ev[`FPS_EV_OV]  = ov_latch_q;
    assign ev[`FPS_EV_OC]  = oc_latch_q;
    assign ev[`FPS_EV_UV]  = uv_latch_q;
    assign ev[`FPS_EV_HOT] = cmp_i.over_temp;

    assign wr_hit = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            irq_stat_q <= '0;
        else if (wr_hit && {avs_address_i[4:2], 2'b00} == 5'(`FPS_REG_IRQ_STAT))
            irq_stat_q <= (irq_stat_q & ~avs_writedata_i[`FPS_EV_W-1:0]) | ev;
        else
            irq_stat_q <= irq_stat_q | ev;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_stat_q & irq_mask_q);
    end

    // ==========================================================
    // avalon slave: one wait cycle, answer on second cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            done_q <= 1'b0;
        else
            done_q <= (avs_read_i || avs_write_i) && !done_q;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            avs_waitrequest_o <= 1'b1;
        else
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !done_q);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            thresh_q   <= `FPS_THRESH_RST;
            reduced_q  <= 1'b0;
            nph_q      <= `FPS_NPH_RST;
            irq_mask_q <= '0;
        end
        else if (wr_hit)
        begin
            if ({avs_address_i[4:2], 2'b00} == 5'(`FPS_REG_CTRL))
            begin
                reduced_q <= avs_writedata_i[`FPS_CTRL_PS_BIT];
                nph_q     <= avs_writedata_i[`FPS_CTRL_NPH_LSB +: 2];
            end
            else if ({avs_address_i[4:2], 2'b00} == 5'(`FPS_REG_THRESH))
                thresh_q <= avs_writedata_i[`FPS_CUR_W-1:0];
            else if ({avs_address_i[4:2], 2'b00} == 5'(`FPS_REG_IRQ_MASK))
                irq_mask_q <= avs_writedata_i[`FPS_EV_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            avs_readdata_o <= 32'h0;
        else if (avs_read_i && !done_q)
        begin
            if ({avs_address_i[4:2], 2'b00} == 5'(`FPS_REG_CTRL))
                avs_readdata_o <= {29'h0, nph_q, reduced_q};
            else if ({avs_address_i[4:2], 2'b00} == 5'(`FPS_REG_THRESH))
                avs_readdata_o <= {20'h0, thresh_q};
            else if ({avs_address_i[4:2], 2'b00} == 5'(`FPS_REG_STATUS))
                avs_readdata_o <= {26'h0, over_cur, state_q, rv_latch_q, ov_latch_q};
            else if ({avs_address_i[4:2], 2'b00} == 5'(`FPS_REG_IRQ_STAT))
                avs_readdata_o <= {27'h0, irq_stat_q};
            else if ({avs_address_i[4:2], 2'b00} == 5'(`FPS_REG_IRQ_MASK))
                avs_readdata_o <= {27'h0, irq_mask_q};
            else
                avs_readdata_o <= 32'h0;
        end
    end
endmodule
`default_nettype wire

// ==== tb/fps_stage_model.sv ====
// power-stage model at the far side of the phase outputs
`timescale 1ns/10ps
`default_nettype none
`include "fps_consts.svh"
module fps_stage_model (
    // phase commands
    input  wire fps_pkg::fps_pwm_t [`FPS_NPH-1:0] pwm_i,
    // gate states
    output logic [`FPS_NPH-1:0]                  hs_on_o,
    output logic [`FPS_NPH-1:0]                  ls_on_o
);
    import fps_pkg::*;
    // hi-z opens both switches so reverse current decays in the diodes
    always_comb
    begin
        for (int g = 0; g < `FPS_NPH; g++)
        begin
            hs_on_o[g] = (pwm_i[g] == FPS_PWM_HIGH);
            ls_on_o[g] = (pwm_i[g] == FPS_PWM_LOW);
        end
    end
endmodule
`default_nettype wire

// ==== tb/fps_supervisor_checker.sv ====
// assertion checker for the fault protection supervisor
`timescale 1ns/10ps
`default_nettype none
`include "fps_consts.svh"
module fps_supervisor_checker (
    // clock and reset
    input  wire logic                            ref_clk_i,
    input  wire logic                            srst_i,
    // watched inputs
    input  wire logic                            enable_i,
    input  wire logic                            supply_ok_i,
    input  wire fps_pkg::fps_cmp_t               cmp_i,
    input  wire logic [`FPS_NPH-1:0]             phase_limit_i,
    input  wire logic                            avs_read_i,
    input  wire logic                            avs_write_i,
    // watched outputs
    input  wire fps_pkg::fps_pwm_t [`FPS_NPH-1:0] pwm_o,
    input  wire logic                            forced_conduction_flag_o,
    input  wire logic                            thermal_alarm_n_o,
    input  wire logic                            avs_waitrequest_o
);
    import fps_pkg::*;
    // ====
    // helpers
    logic                all_hiz;
    logic                all_low;
    logic                en_ok;
    logic [`FPS_NPH-1:0] hi_vec;
    logic [13:0]         uv_run_q;
    assign en_ok = enable_i && supply_ok_i;
    always_comb
    begin
        all_hiz = 1'b1;
        all_low = 1'b1;
        for (int g = 0; g < `FPS_NPH; g++)
        begin
            all_hiz &= (pwm_o[g] == FPS_PWM_HIZ);
            all_low &= (pwm_o[g] == FPS_PWM_LOW);
            hi_vec[g] = (pwm_o[g] == FPS_PWM_HIGH);
        end
    end
    // saturates so a long fault never wraps back to a match
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || !cmp_i.under_volt)
            uv_run_q <= 14'h0;
        else if (uv_run_q != 14'h3fff)
            uv_run_q <= uv_run_q + 14'h1;
    end
    // ====
    // properties
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    sequence s_req_taken;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_one_wait;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    a_rev_hiz: assert property (cmp_i.rev_volt |-> ##[1:3] all_hiz)
        else $error("reverse voltage left a phase driven");
    a_ov_low: assert property (cmp_i.ov_fixed && en_ok && !cmp_i.rev_volt
        |-> ##[1:3] ((all_low && forced_conduction_flag_o) || !en_ok || cmp_i.rev_volt))
        else $error("fixed over-voltage did not latch phases low");
    a_hot_alarm: assert property (cmp_i.over_temp |=> !thermal_alarm_n_o)
        else $error("thermal alarm not low after over-temperature");
    a_off_hiz: assert property (!en_ok [*3] |-> all_hiz)
        else $error("phases driven while disabled");
    a_wait_one: assert property (s_req_taken |=> s_one_wait)
        else $error("bus answer not one cycle after request");
    a_idle_wait: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("waitrequest low while idle");
    a_uv_latch: assert property (uv_run_q == 14'(`FPS_PERSIST_CYC) && en_ok |-> ##[0:3] all_hiz)
        else $error("lasting under-voltage did not float phases");
    a_limit_cut: assert property (phase_limit_i != '0 |=> (hi_vec & $past(phase_limit_i)) == '0)
        else $error("limited phase still switched high");
endmodule
bind fps_supervisor fps_supervisor_checker i_chk (
    .ref_clk_i, .srst_i, .enable_i, .supply_ok_i, .cmp_i, .phase_limit_i, .avs_read_i,
    .avs_write_i, .pwm_o, .forced_conduction_flag_o, .thermal_alarm_n_o, .avs_waitrequest_o
);
`default_nettype wire

// ==== tb/fps_supervisor_tb.sv ====
// self-checking testbench of the fault protection supervisor
`timescale 1ns/10ps
`default_nettype none
`include "fps_consts.svh"
module fps_supervisor_tb;
    import fps_pkg::*;
    localparam logic [7:0] HIZ4 = {4{FPS_PWM_HIZ}};
    localparam logic [7:0] LOW4 = {4{FPS_PWM_LOW}};
    logic ref_clk = 1'b0, srst = 1'b1, enable = 1'b0, supply_ok = 1'b0;
    logic final_tgt = 1'b0, vid_tr = 1'b0, rd = 1'b0, wr_en = 1'b0;
    fps_cmp_t cmp = '0;
    logic [11:0] sum = '0;
    logic [3:0] limit = '0, mod = '0, hs_on, ls_on;
    logic [4:0] addr = '0;
    logic [31:0] wdata = '0, rdata;
    fps_pwm_t [3:0] pwm;
    logic flag, alarm_n, irq, waitreq;
    int fail_count = 0, checks_done = 0;
    always #50 ref_clk = ~ref_clk;
    fps_supervisor i_dut (.ref_clk_i(ref_clk), .srst_i(srst), .enable_i(enable),
        .supply_ok_i(supply_ok), .cmp_i(cmp), .final_target_flag_i(final_tgt),
        .vid_transition_i(vid_tr), .summed_current_sense_i(sum), .phase_limit_i(limit),
        .pwm_mod_i(mod), .pwm_o(pwm), .forced_conduction_flag_o(flag),
        .thermal_alarm_n_o(alarm_n), .irq_o(irq), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq));
    fps_stage_model i_stage (.pwm_i(pwm), .hs_on_o(hs_on), .ls_on_o(ls_on));
    // ====
    // tasks
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] mk(input logic [3:0] m);
        for (int g = 0; g < 4; g++)
            mk[2*g+:2] = m[g] ? FPS_PWM_HIGH : FPS_PWM_LOW;
    endfunction
    // the stage model must see the same phase states as the pins
    task automatic chk_pwm(input logic [7:0] e);
        logic [3:0] h;
        logic [3:0] l;
        for (int g = 0; g < 4; g++)
        begin
            h[g] = (e[2*g+:2] == FPS_PWM_HIGH);
            l[g] = (e[2*g+:2] == FPS_PWM_LOW);
        end
        chk(32'(pwm), 32'(e));
        chk(32'(hs_on), 32'(h));
        chk(32'(ls_on), 32'(l));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd <= !w;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        wr_en <= 1'b0;
        rd <= 1'b0;
        if (waitreq !== 1'b0)
        begin
            fail_count++;
            tally_and_finish();
        end
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // one-cycle comparator hit, then time for latch and output stage
    task automatic hit(input logic [4:0] c);
        cmp <= fps_cmp_t'(c);
        tick(1);
        cmp <= '0;
        tick(3);
    endtask
    task automatic cycle_en();
        enable <= 1'b0;
        tick(3);
        enable <= 1'b1;
        tick(4);
    endtask
    // ====
    // scenarios
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        logic [11:0] lim;
        tick(3);
        srst <= 1'b0;
        tick(1);
        chk_pwm(HIZ4);
        rd_chk(5'h04, 32'hfff);
        rd_chk(5'h00, 32'h0);
        wr(5'h14, 32'hffffffff);
        rd_chk(5'h14, 32'h0);
        wr(5'h10, 32'h0);
        mod <= 4'b0101;
        enable <= 1'b1;
        supply_ok <= 1'b1;
        tick(4);
        chk_pwm(mk(4'b0101));
        limit <= 4'b0001;
        tick(3);
        chk_pwm(mk(4'b0100));
        limit <= 4'h0;
        cmp.over_temp <= 1'b1;
        tick(3);
        chk(32'(alarm_n), 32'h0);
        chk(32'(irq), 32'h0);
        wr(5'h10, 32'h10);
        tick(2);
        chk(32'(irq), 32'h1);
        cmp.over_temp <= 1'b0;
        tick(2);
        wr(5'h0c, 32'h10);
        tick(2);
        chk(32'(irq), 32'h0);
        chk(32'(alarm_n), 32'h1);
        hit(5'h08);
        chk_pwm(LOW4);
        chk(32'(flag), 32'h1);
        hit(5'h10);
        chk_pwm(HIZ4);
        chk(32'(flag), 32'h0);
        hit(5'h04);
        chk_pwm(HIZ4);
        final_tgt <= 1'b1;
        tick(2);
        final_tgt <= 1'b0;
        vid_tr <= 1'b1;
        tick(2);
        hit(5'h04);
        chk_pwm(HIZ4);
        vid_tr <= 1'b0;
        tick(1);
        hit(5'h04);
        chk_pwm(LOW4);
        hit(5'h10);
        enable <= 1'b0;
        tick(3);
        chk_pwm(HIZ4);
        enable <= 1'b1;
        tick(4);
        chk_pwm(mk(4'b0101));
        hit(5'h08);
        supply_ok <= 1'b0;
        tick(3);
        supply_ok <= 1'b1;
        tick(4);
        chk_pwm(mk(4'b0101));
        cmp.under_volt <= 1'b1;
        tick(9990);
        chk_pwm(mk(4'b0101));
        tick(20);
        chk_pwm(HIZ4);
        cmp.under_volt <= 1'b0;
        tick(3);
        chk_pwm(HIZ4);
        cycle_en();
        wr(5'h04, 32'h400);
        mod <= 4'hf;
        for (int k = 0; k < 4; k++)
        begin
            lim = (k == 0) ? 12'h400 : 12'(32'h400 / (5 - k));
            wr(5'h00, (k == 0) ? 32'h0 : {29'h0, 2'(k - 1), 1'b1});
            sum <= lim;
            tick(4);
            chk_pwm(mk(4'hf));
            sum <= lim + 12'h1;
            tick(4);
            chk_pwm(LOW4);
            sum <= '0;
            tick(1);
        end
        wr(5'h00, 32'h0);
        sum <= 12'h401;
        tick(9990);
        chk_pwm(LOW4);
        tick(20);
        chk_pwm(HIZ4);
        sum <= '0;
        wr(5'h0c, 32'h1f);
        rd_chk(5'h0c, 32'h04);
        rd_chk(5'h08, 32'h10);
        chk_pwm(HIZ4);
        cycle_en();
        chk_pwm(mk(4'hf));
        tally_and_finish();
    end
endmodule
`default_nettype wire
